// ---- wws_top.sv ----
// windowed watchdog with reset generator and manual reset
`timescale 1ns/1ps
`include "wws_map.svh"
// Contract
// RQ1: manual reset low forces reset, clears watchdog timer, releases fault output.
// RQ2: watchdog timer clears on each kick falling edge and on reset release.
// RQ3: a kick edge inside the window leaves the fault output high.
// RQ4: a kick edge too early or too late gives one low fault pulse.
// RQ5: fault output pulses only while reset output is high.
// RQ6: two kick edges closer than the fast limit raise a fast fault.
// RQ7: no kick edge within the slow limit raises a slow fault.
// RQ8: timer clears on valid edge, reset release and fault release.
// RQ9: kicks are ignored while reset or fault output is low.
// RQ10: first kick after reset or fault release skips the fast check.
// RQ11: fault output stays low for a fixed one millisecond pulse.
// RQ12: reset is low while supply is below threshold.
// RQ13: reset stays low at least 100 ms after both causes clear.
// RQ14: reset asserts if supply low or manual reset low.
// RQ15: short manual reset glitches are rejected; driver holds it low 1 us.
// RQ16: fast and slow limits are build options set by parameters.
// RQ17: slow fault fires once the full slow period expires without an edge.
// RQ18: inputs are synchronised and all times are counted in clock cycles.
module wws_top #(
    parameter int FAST_CYC  = `WWS_FAST_CYC,                  // [RQ16]
    parameter int SLOW_CYC  = `WWS_SLOW_CYC,
    parameter int FAULT_CYC = `WWS_FAULT_CYC,
    parameter int HOLD_CYC  = `WWS_HOLD_CYC
) (
    input  wire logic i_sys_clk,
    input  wire logic i_arst_n,
    input  wire logic i_watchdog_kick,
    input  wire logic i_manual_reset_n,
    input  wire logic i_supply_low,
    output logic      o_reset_n,
    output logic      o_watchdog_fault_pulse_n,
    output logic      o_fault_oe_n,
    output logic      o_fast_fault,
    output logic      o_slow_fault
);
    localparam int TW = $clog2(SLOW_CYC + 2);
    localparam int HW = $clog2(HOLD_CYC + 2);
    localparam int PW = $clog2(FAULT_CYC + 2);

    logic               rs1_r;
    logic               rst_n;
    wws_pkg::wws_in_s   pin;
    wws_pkg::wws_state_e state_r;
    wws_pkg::wws_state_e state_nxt;
    logic               kick_d_r;
    logic [TW-1:0]      tmr_r;
    logic [HW-1:0]      hold_r;
    logic [PW-1:0]      pulse_r;
    logic               first_r;
    logic               fast_r;
    logic               slow_r;

    // reset release through two flops
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    // pins cross into the clock domain; manual reset also filtered [RQ18] [RQ15]
    wws_sync_filt #(.FILT_CYC(`WWS_GLITCH_CYC), .RST_VAL(1'b1)) u_mr (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n),
        .i_pin     (i_manual_reset_n),
        .o_level   (pin.mr_n)
    );
    wws_sync_filt #(.FILT_CYC(1), .RST_VAL(1'b1)) u_kick (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n),
        .i_pin     (i_watchdog_kick),
        .o_level   (pin.kick)
    );
    // treat supply low as asserted until synchroniser settles: safe side
    wws_sync_filt #(.FILT_CYC(1), .RST_VAL(1'b1)) u_sup (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n),
        .i_pin     (i_supply_low),
        .o_level   (pin.supply_low)
    );

    wire cause     = pin.supply_low || !pin.mr_n;             // [RQ12] [RQ14]
    wire hold_done = (hold_r >= HW'(HOLD_CYC));
    wire reset_act = cause || !hold_done;                     // [RQ13]

    // reset stretch counter restarts while any cause is present [RQ13]
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= '0;
        end else if (cause) begin
            hold_r <= '0;
        end else if (!hold_done) begin
            hold_r <= hold_r + 1'b1;
        end
    end

    wire kick_fall  = kick_d_r && !pin.kick;
    wire in_fault   = (state_r == wws_pkg::WWS_FAULT);
    wire pulse_end  = in_fault && (pulse_r >= PW'(FAULT_CYC - 1));
    wire edge_valid = kick_fall && !in_fault;                 // [RQ9]
    wire is_fast    = edge_valid && !first_r && (tmr_r < TW'(FAST_CYC));  // [RQ6] [RQ10]
    wire is_slow    = !in_fault && (tmr_r >= TW'(SLOW_CYC));  // [RQ7] [RQ17]
    wire go_fault   = (state_r == wws_pkg::WWS_ARMED) && (is_fast || is_slow); // [RQ4]

    // watchdog sequencing; held idle under reset [RQ1] [RQ5]
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            wws_pkg::WWS_IDLE:  state_nxt = wws_pkg::WWS_ARMED;
            wws_pkg::WWS_ARMED: if (go_fault) state_nxt = wws_pkg::WWS_FAULT;
            wws_pkg::WWS_FAULT: if (pulse_end) state_nxt = wws_pkg::WWS_ARMED; // [RQ11]
        endcase
        if (reset_act) state_nxt = wws_pkg::WWS_IDLE;
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= wws_pkg::WWS_IDLE;
            kick_d_r <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            kick_d_r <= pin.kick;
        end
    end

    // watchdog timer: clears on valid edge, on reset or fault release [RQ2] [RQ8] [RQ3]
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_r   <= '0;
            first_r <= 1'b1;
        end else if (state_r != wws_pkg::WWS_ARMED || go_fault) begin
            tmr_r   <= '0;                                    // [RQ1]
            first_r <= 1'b1;                                  // [RQ10]
        end else if (edge_valid) begin
            tmr_r   <= '0;
            first_r <= 1'b0;
        end else if (!is_slow) begin
            tmr_r <= tmr_r + 1'b1;
        end
    end

    // fixed-width fault pulse timer [RQ11]
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_r <= '0;
        end else if (!in_fault) begin
            pulse_r <= '0;
        end else begin
            pulse_r <= pulse_r + 1'b1;
        end
    end

    // registered outputs; fault cause flags mark the pulse kind
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reset_n <= 1'b0;
            fast_r    <= 1'b0;
            slow_r    <= 1'b0;
        end else begin
            o_reset_n <= !reset_act;                          // [RQ14]
            if (go_fault) begin
                fast_r <= is_fast;
                slow_r <= !is_fast;
            end else if (state_nxt != wws_pkg::WWS_FAULT) begin
                fast_r <= 1'b0;
                slow_r <= 1'b0;
            end
        end
    end

    // open-drain: enable low only while pulling low [RQ5]
    assign o_watchdog_fault_pulse_n = !in_fault;
    assign o_fault_oe_n             = !in_fault;
    assign o_fast_fault             = fast_r;
    assign o_slow_fault             = slow_r;
endmodule

// ---- wws_map.svh ----
// timing constants for the windowed watchdog supervisor
`ifndef WWS_MAP_SVH
`define WWS_MAP_SVH
`define WWS_CLK_HZ        10000000
`define WWS_FAST_US       1500
`define WWS_SLOW_US       15000
`define WWS_FAULT_US      1000
`define WWS_HOLD_US       100000
`define WWS_GLITCH_NS     100
`define WWS_US_CYC(us)    (((us) * (`WWS_CLK_HZ / 1000000)))
`define WWS_FAST_CYC      `WWS_US_CYC(`WWS_FAST_US)
`define WWS_SLOW_CYC      `WWS_US_CYC(`WWS_SLOW_US)
`define WWS_FAULT_CYC     `WWS_US_CYC(`WWS_FAULT_US)
`define WWS_HOLD_CYC      `WWS_US_CYC(`WWS_HOLD_US)
// glitch filter: one cycle more than the rejected width, rounded up
`define WWS_GLITCH_CYC    (((`WWS_GLITCH_NS) * (`WWS_CLK_HZ / 1000000) + 999) / 1000 + 1)
`endif

// ---- wws_pkg.sv ----
// types for the windowed watchdog supervisor
package wws_pkg;
    typedef enum logic [1:0] {WWS_IDLE, WWS_ARMED, WWS_FAULT} wws_state_e;
    typedef struct packed {
        logic kick;
        logic mr_n;
        logic supply_low;
    } wws_in_s;
endpackage

// ---- wws_sync_filt.sv ----
// three-stage pin synchroniser with optional level filter
`timescale 1ns/1ps
module wws_sync_filt #(
    parameter int FILT_CYC = 1,
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_pin,
    output logic      o_level
);
    localparam int CW = $clog2(FILT_CYC + 1) + 1;
    logic          s1_r;
    logic          s2_r;
    logic          s3_r;
    logic [CW-1:0] cnt_r;
    wire           agree = (s2_r == s3_r);
    wire           diff  = agree && (s3_r != o_level);
    // s1 is read only by s2
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // a new level must stay stable for FILT_CYC + 1 cycles before it counts (s2 and s3 must agree)
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r   <= '0;
            o_level <= RST_VAL;
        end else if (!diff) begin
            cnt_r <= '0;
        end else if (cnt_r >= CW'(FILT_CYC - 1)) begin
            cnt_r   <= '0;
            o_level <= s3_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule

// ---- wws_top_chk.sv ----
// port assertions for the watchdog supervisor
`timescale 1ns/1ps
module wws_top_chk #(
    parameter int FAULT_CYC = 16,
    parameter int SLOW_CYC  = 200,
    parameter int HOLD_CYC  = 100
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_watchdog_kick,
    input wire logic i_manual_reset_n,
    input wire logic i_supply_low,
    input wire logic o_reset_n,
    input wire logic o_watchdog_fault_pulse_n,
    input wire logic o_fast_fault,
    input wire logic o_slow_fault
);
    int   low_r, clr_r, quiet_r;
    logic kick_r;
    wire  kick_fall = kick_r && !i_watchdog_kick;
    // pin-side counters; bounds below leave slack for the synchroniser
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_r   <= 0;
            clr_r   <= 0;
            quiet_r <= 0;
            kick_r  <= 1'b1;
        end else begin
            kick_r  <= i_watchdog_kick;
            low_r   <= o_watchdog_fault_pulse_n ? 0 : low_r + 1;
            clr_r   <= (i_supply_low || !i_manual_reset_n) ? 0 : clr_r + 1;
            quiet_r <= (!o_reset_n || !o_watchdog_fault_pulse_n || kick_fall) ? 0 : quiet_r + 1;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    a_mr_forces_reset: assert property (
        !i_manual_reset_n [*8] |=> !o_reset_n && o_watchdog_fault_pulse_n)
        else $error("mr ignored");
    a_supply_forces_reset: assert property (
        i_supply_low [*8] |=> !o_reset_n) else $error("supply low ignored");
    a_quiet_in_reset: assert property (
        !o_reset_n [*2] |-> o_watchdog_fault_pulse_n) else $error("pulse in reset");
    a_pulse_needs_run: assert property (
        $fell(o_watchdog_fault_pulse_n) |-> o_reset_n) else $error("pulse start in reset");
    a_pulse_width_exact: assert property (
        $rose(o_watchdog_fault_pulse_n) && clr_r > 12 |-> low_r == FAULT_CYC) else $error("width");
    a_fault_kind_flag: assert property (
        $fell(o_watchdog_fault_pulse_n) |=> o_fast_fault != o_slow_fault) else $error("flag");
    a_hold_stretch: assert property (
        $rose(o_reset_n) |-> clr_r >= HOLD_CYC) else $error("reset too short");
    a_slow_bound: assert property (
        quiet_r <= SLOW_CYC + 12) else $error("slow fault late");
endmodule
bind wws_top wws_top_chk #(.FAULT_CYC(FAULT_CYC), .SLOW_CYC(SLOW_CYC), .HOLD_CYC(HOLD_CYC))
    u_chk (.i_sys_clk, .i_arst_n, .i_watchdog_kick, .i_manual_reset_n, .i_supply_low,
    .o_reset_n, .o_watchdog_fault_pulse_n, .o_fast_fault, .o_slow_fault);

// ---- wws_cpu.sv ----
// processor model toggling the kick pin at a set half period
`timescale 1ns/1ps
module wws_cpu (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_run,
    input  wire logic [15:0] i_half,
    output logic             o_kick = 1'b1
);
    logic [15:0] cnt_r;
    // a core held in reset stops kicking and parks the pin high
    always @(posedge i_sys_clk) begin
        if (!i_reset_n || !i_run) begin
            cnt_r  <= 16'h0000;
            o_kick <= 1'b1;
        end else if (cnt_r + 16'h0001 >= i_half) begin
            cnt_r  <= 16'h0000;
            o_kick <= ~o_kick;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule

// ---- wws_top_bench.sv ----
// self-checking bench for the windowed watchdog supervisor
`timescale 1ns/1ps
module wws_top_bench;
    logic i_sys_clk = 1'b0, i_arst_n, i_manual_reset_n = 1'b1, i_supply_low = 1'b0;
    logic i_watchdog_kick, o_reset_n, o_watchdog_fault_pulse_n, o_fault_oe_n;
    logic o_fast_fault, o_slow_fault, run = 1'b0;
    logic [15:0] half = 16'h001e;
    int num_errors = 0, samples_checked = 0, pulses = 0, p0;
    // shortened counts keep the run brief
    wws_top #(.FAST_CYC(20), .SLOW_CYC(200), .FAULT_CYC(16), .HOLD_CYC(100)) dut (.*);
    wws_cpu cpu (.i_sys_clk, .i_reset_n(o_reset_n), .i_run(run), .i_half(half),
        .o_kick(i_watchdog_kick));
    initial forever #50 i_sys_clk = ~i_sys_clk;
    always @(negedge o_watchdog_fault_pulse_n) pulses++;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    // bounded wait for a level on reset or on the fault pulse
    task automatic wait_lvl(input logic pls, input logic lvl, input int lim);
        for (int i = 0; i < lim && (pls ? o_watchdog_fault_pulse_n : o_reset_n) !== lvl; i++)
            cyc(1);
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic stretch();
        cyc(50);
        check("reset held", o_reset_n, 0);
        wait_lvl(0, 1, 140);
        check("reset up", o_reset_n, 1);
    endtask
    task automatic t_fault(input logic fast, input int lim);
        p0 = pulses;
        wait_lvl(1, 0, lim);
        check("oe", o_fault_oe_n, 0);
        cyc(2);
        check("fast", o_fast_fault, fast);
        check("slow", o_slow_fault, !fast);
        cyc(13);
        check("width low", o_watchdog_fault_pulse_n, 0);
        cyc(1);
        check("width end", o_watchdog_fault_pulse_n, 1);
        run <= 1'b0;
        cyc(5);
        check("one pulse", pulses - p0, 1);
    endtask
    task automatic t_normal();
        p0 = pulses;
        run <= 1'b1;
        cyc(700);
        check("no pulse", pulses - p0, 0);
    endtask
    task automatic t_mr();
        // edges 24 apart are valid, but the first lands early after any release
        half <= 16'h000c;
        run <= 1'b1;
        i_manual_reset_n <= 1'b0;
        cyc(1);
        i_manual_reset_n <= 1'b1;
        cyc(10);
        check("glitch", o_reset_n, 1);
        i_manual_reset_n <= 1'b0;
        cyc(10);
        check("mr reset", o_reset_n, 0);
        check("mr pulse", o_watchdog_fault_pulse_n, 1);
        i_manual_reset_n <= 1'b1;
        stretch();
    endtask
    task automatic t_supply();
        p0 = pulses;
        i_supply_low <= 1'b1;
        i_manual_reset_n <= 1'b0;
        cyc(10);
        check("supply reset", o_reset_n, 0);
        i_supply_low <= 1'b0;
        cyc(130);
        check("mr still", o_reset_n, 0);
        i_manual_reset_n <= 1'b1;
        stretch();
        cyc(60);
        check("no pulse", pulses - p0, 0);
    endtask
    initial begin
        // an edge on reset at time zero clears the design before the first clock
        i_arst_n <= 1'b0;
        cyc(3);
        i_arst_n <= 1'b1;
        stretch();
        t_normal();
        half <= 16'h0005;
        t_fault(1, 200);
        t_fault(0, 240);
        t_mr();
        t_supply();
        wrap_up();
    end
    initial begin
        cyc(5000);
        num_errors++;
        wrap_up();
    end
endmodule
